// ===== aklp_consts.svh
// Constants of the layer-4 / OAM / payload key builder.
// Assumes byte offsets count from the first byte of the destination MAC.
`ifndef AKLP_CONSTS_SVH
`define AKLP_CONSTS_SVH

`define AKLP_ADDR_W 8
`define AKLP_DATA_W 32
`define AKLP_OFS_W 10
`define AKLP_PTR_W 8
`define AKLP_NUM_RNG 8
`define AKLP_RNG_SEL_W 3

`define AKLP_REG_BOUND_BASE 8'h00
`define AKLP_REG_RNG_TYPE 8'h20
`define AKLP_REG_CUST_OFS 8'h24
`define AKLP_REG_KEY_STAT 8'h28
`define AKLP_REG_KEY_CNT 8'h2c
`define AKLP_RST_BOUND 32'hffff_0000
`define AKLP_RST_RNG_TYPE 24'h00_0000
`define AKLP_RST_CUST_OFS 10'h000

`define AKLP_ETHERTYPE_KEY_FIELD_POS 10'h00c
`define AKLP_VLAN_TAG_LEN 10'h004
`define AKLP_ETHERTYPE_KEY_FIELD_LEN 10'h002
`define AKLP_MAX_TAGS 3
`define AKLP_TPID_C 16'h8100
`define AKLP_TPID_S 16'h88a8
`define AKLP_TPID_X 16'h9100
`define AKLP_ETHERTYPE_KEY_FIELD_IPV4 16'h0800
`define AKLP_ETHERTYPE_KEY_FIELD_IPV6 16'h86dd
`define AKLP_ETHERTYPE_KEY_FIELD_OAM 16'h8902
`define AKLP_PROTO_TCP 8'h06
`define AKLP_PROTO_UDP 8'h11
`define AKLP_IPV4_HDR_LEN 10'h014
`define AKLP_IPV6_HDR_LEN 10'h028
`define AKLP_IPV4_PROTO_POS 10'h009
`define AKLP_IPV6_NH_POS 10'h006
`define AKLP_UDP_HDR_LEN 10'h008
`define AKLP_TCP_SEQ_POS 10'h004
`define AKLP_TCP_DOFS_POS 10'h00c
`define AKLP_TCP_FLAG_POS 10'h00d
`define AKLP_CCM_OPCODE 8'h01
`define AKLP_CCM_CNT_POS 10'h03a

`define AKLP_IP_SNIP_BYTES 12
`define AKLP_L4_SNIP_BYTES 8
`define AKLP_WIDE_BYTES 57
`define AKLP_NARROW_BYTES 24
`define AKLP_CCM_CNT_BYTES 12

`endif

// ===== aklp_pkg.sv
// Types shared by the key builder and its helpers.
// Assumes aklp_consts.svh is on the include path.
`include "aklp_consts.svh"

package aklp_pkg;

    typedef enum logic [2:0] {
        AKLP_ST_COLLECT = 3'b001,
        AKLP_ST_PARSE = 3'b010,
        AKLP_ST_BUILD = 3'b100
    } aklp_state_t;

    typedef enum logic [`AKLP_RNG_SEL_W-1:0] {
        AKLP_RNG_SPORT = 3'h0,
        AKLP_RNG_DPORT = 3'h1,
        AKLP_RNG_EITHER = 3'h2,
        AKLP_RNG_VID = 3'h3,
        AKLP_RNG_DSCP = 3'h4,
        AKLP_RNG_CUSTOM = 3'h5
    } aklp_rng_sel_t;

    typedef struct packed {
        logic [11:0] vid;
        logic [5:0] dscp;
        logic is_eth;
        logic [`AKLP_PTR_W-1:0] wide_ptr;
        logic [`AKLP_PTR_W-1:0] narrow_ptr;
    } aklp_class_t;

    typedef struct packed {
        logic [`AKLP_NUM_RNG-1:0] range_check_mask;
        logic src_port_equals_dst_port;
        logic tcp_seq_is_zero;
        logic tcp_fin_bit;
        logic tcp_syn_bit;
        logic tcp_rst_bit;
        logic tcp_psh_bit;
        logic tcp_ack_bit;
        logic tcp_urg_bit;
        logic is_tcp_or_udp;
        logic [`AKLP_IP_SNIP_BYTES*8-1:0] ip_payload_snippet;
        logic [`AKLP_L4_SNIP_BYTES*8-1:0] transport_payload_snippet;
        logic ccm_loss_counters_zero;
        logic oam_ethertype_flag;
        logic [15:0] ethertype_key_field;
        logic [`AKLP_WIDE_BYTES*8-1:0] custom_window_wide;
        logic [`AKLP_NARROW_BYTES*8-1:0] custom_window_narrow;
    } aklp_key_t;

endpackage : aklp_pkg

// ===== aklp_window.sv
// Picks NB consecutive bytes out of a captured frame image.
// Assumes byte 0 of the image sits in the lowest eight bits.
`timescale 1ns/1ps
`default_nettype none

module aklp_window #(
    parameter int FB = 256,
    parameter int NB = 8,
    parameter int OW = 10
) (
    // Frame image and start position
    input wire logic [FB*8-1:0] frame,
    input wire logic [OW-1:0] ofs,
    // First byte lands in the top lane
    output logic [NB*8-1:0] win
);
    always_comb begin
        int idx;
        idx = 0;
        for (int i = 0; i < NB; i++) begin
            idx = int'(ofs) + i;
            // Past the captured image reads as zero
            if (idx < FB) begin
                win[(NB-1-i)*8 +: 8] = frame[idx*8 +: 8];
            end else begin
                win[(NB-1-i)*8 +: 8] = 8'h00;
            end
        end
    end
endmodule : aklp_window

`default_nettype wire

// ===== aklp_range_chk.sv
// One range checker: selects an input, compares against bounds.
// Assumes all inputs are stable registered values of one frame.
`timescale 1ns/1ps
`default_nettype none

module aklp_range_chk (
    // Configuration
    input wire aklp_pkg::aklp_rng_sel_t sel,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi,
    // Candidate values
    input wire logic [15:0] sport,
    input wire logic [15:0] dport,
    input wire logic [11:0] vid,
    input wire logic [5:0] dscp,
    input wire logic [15:0] custom,
    // Result
    output logic hit
);
    import aklp_pkg::*;

    function automatic logic in_rng(input logic [15:0] v,
                                    input logic [15:0] l,
                                    input logic [15:0] h);
        return (v >= l) && (v <= h);
    endfunction : in_rng

    always_comb begin
        case (sel)
            AKLP_RNG_SPORT: hit = in_rng(sport, lo, hi);
            AKLP_RNG_DPORT: hit = in_rng(dport, lo, hi);
            AKLP_RNG_EITHER: hit = in_rng(sport, lo, hi) |
                                   in_rng(dport, lo, hi);
            AKLP_RNG_VID: hit = in_rng({4'h0, vid}, lo, hi);
            AKLP_RNG_DSCP: hit = in_rng({10'h000, dscp}, lo, hi);
            AKLP_RNG_CUSTOM: hit = in_rng(custom, lo, hi);
            default: hit = 1'b0;
        endcase
    end
endmodule : aklp_range_chk

`default_nettype wire

// ===== aklp_key_l4.sv
// Layer-4, OAM and payload part of the access-control lookup key.
// Assumes a byte stream from a parser on the same clock, with the
// classification results valid beside the first byte of a frame.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aklp_consts.svh"
module aklp_key_l4 #(
    parameter int MAXB = 256
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Frame byte stream
    input wire logic in_valid,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [7:0] in_byte,
    input wire aklp_pkg::aklp_class_t in_class,
    output logic in_ready,
    // Key towards the match engine
    output logic key_valid,
    output aklp_pkg::aklp_key_t key,
    // Register port
    input wire logic [`AKLP_ADDR_W-1:0] reg_addr,
    input wire logic [`AKLP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`AKLP_DATA_W-1:0] reg_rdata
);
    import aklp_pkg::*;

    localparam int OW = `AKLP_OFS_W;
    localparam int NR = `AKLP_NUM_RNG;
    localparam int SW = `AKLP_RNG_SEL_W;

    // Reset synchroniser
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Software-visible configuration
    logic [`AKLP_DATA_W-1:0] bound_r [NR];
    logic [NR*SW-1:0] rng_type_r;
    logic [OW-1:0] cust_ofs_r;
    logic [`AKLP_DATA_W-1:0] key_cnt_r;
    logic [`AKLP_DATA_W-1:0] rdata_r;

    // Capture state
    aklp_state_t state_r;
    logic in_ready_r;
    logic in_frame_r;
    logic [OW-1:0] wr_ptr_r;
    logic [MAXB*8-1:0] frame_r;
    aklp_class_t cls_r;

    // Parse results
    logic [OW-1:0] l2_end_r;
    logic [OW-1:0] l4_ofs_r;
    logic [OW-1:0] l4_pay_r;
    logic [OW-1:0] wide_ofs_r;
    logic [OW-1:0] narrow_ofs_r;
    logic tcp_r;
    logic is_tcp_or_udp_r;
    logic oam_r;
    logic ccm_r;
    logic [15:0] ethertype_key_field_r;
    logic [2:0] mel_r;
    logic [15:0] sport_r;
    logic [15:0] dport_r;
    logic [31:0] seq_r;
    logic [7:0] tflags_r;
    logic [15:0] custom_val_r;

    // Output registers
    logic key_valid_r;
    aklp_key_t key_r;

    function automatic logic [7:0] fbyte(input logic [OW-1:0] i);
        if (int'(i) < MAXB) begin
            return frame_r[int'(i)*8 +: 8];
        end
        return 8'h00;
    endfunction : fbyte

    function automatic logic [15:0] fword(input logic [OW-1:0] i);
        return {fbyte(i), fbyte(OW'(i + 1'b1))};
    endfunction : fword

    function automatic logic is_tpid(input logic [15:0] w);
        return (w == `AKLP_TPID_C) || (w == `AKLP_TPID_S) ||
               (w == `AKLP_TPID_X);
    endfunction : is_tpid

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NR; i++) begin
                bound_r[i] <= `AKLP_RST_BOUND;
            end
            rng_type_r <= `AKLP_RST_RNG_TYPE;
            cust_ofs_r <= `AKLP_RST_CUST_OFS;
        end else if (reg_wr) begin
            if (reg_addr < `AKLP_REG_RNG_TYPE && reg_addr[1:0] == 2'b00) begin
                bound_r[reg_addr[4:2]] <= reg_wdata;
            end else if (reg_addr == `AKLP_REG_RNG_TYPE) begin
                rng_type_r <= reg_wdata[NR*SW-1:0];
            end else if (reg_addr == `AKLP_REG_CUST_OFS) begin
                cust_ofs_r <= reg_wdata[OW-1:0];
            end
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr < `AKLP_REG_RNG_TYPE && reg_addr[1:0] == 2'b00) begin
                rdata_r <= bound_r[reg_addr[4:2]];
            end else if (reg_addr == `AKLP_REG_RNG_TYPE) begin
                rdata_r <= {{(32-NR*SW){1'b0}}, rng_type_r};
            end else if (reg_addr == `AKLP_REG_CUST_OFS) begin
                rdata_r <= {{(32-OW){1'b0}}, cust_ofs_r};
            end else if (reg_addr == `AKLP_REG_KEY_STAT) begin
                rdata_r <= {16'h0000, key_r.oam_ethertype_flag,
                            key_r.ccm_loss_counters_zero,
                            key_r.is_tcp_or_udp,
                            key_r.tcp_seq_is_zero,
                            key_r.src_port_equals_dst_port,
                            state_r, key_r.range_check_mask};
            end else if (reg_addr == `AKLP_REG_KEY_CNT) begin
                rdata_r <= key_cnt_r;
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    // Sequencer: collect a frame, parse it, build the key
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= AKLP_ST_COLLECT;
            in_ready_r <= 1'b0;
            in_frame_r <= 1'b0;
        end else begin
            case (state_r)
                AKLP_ST_COLLECT: begin
                    in_ready_r <= 1'b1;
                    if (in_valid && in_ready_r) begin
                        if (in_sop) begin
                            in_frame_r <= ~in_eop;
                        end else if (in_eop) begin
                            in_frame_r <= 1'b0;
                        end
                        if (in_eop && (in_sop || in_frame_r)) begin
                            state_r <= AKLP_ST_PARSE;
                            in_ready_r <= 1'b0;
                        end
                    end
                end
                AKLP_ST_PARSE: begin
                    state_r <= AKLP_ST_BUILD;
                end
                AKLP_ST_BUILD: begin
                    state_r <= AKLP_ST_COLLECT;
                    in_ready_r <= 1'b1;
                end
                default: begin
                    state_r <= AKLP_ST_COLLECT;
                    in_ready_r <= 1'b0;
                end
            endcase
        end
    end

    // Frame image capture; stale bytes cleared at each frame start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_r <= '0;
            wr_ptr_r <= '0;
            cls_r <= '0;
        end else if (state_r == AKLP_ST_COLLECT && in_valid && in_ready_r) begin
            if (in_sop) begin
                frame_r <= '0;
                frame_r[7:0] <= in_byte;
                wr_ptr_r <= OW'(1);
                cls_r <= in_class;
            end else if (in_frame_r && int'(wr_ptr_r) < MAXB) begin
                frame_r[int'(wr_ptr_r)*8 +: 8] <= in_byte;
                wr_ptr_r <= OW'(wr_ptr_r + 1'b1);
            end
        end
    end

    // Header walk, done in the parse cycle
    always_ff @(posedge clk or negedge rst_n) begin
        logic [OW-1:0] pos;
        logic [OW-1:0] l2e;
        logic [OW-1:0] l4o;
        logic [15:0] et;
        logic [7:0] proto;
        logic ip4;
        logic ip6;
        logic tu;
        logic [OW-1:0] cbase;
        pos = `AKLP_ETHERTYPE_KEY_FIELD_POS;
        l2e = '0;
        l4o = '0;
        et = '0;
        proto = '0;
        ip4 = 1'b0;
        ip6 = 1'b0;
        tu = 1'b0;
        cbase = '0;
        if (!rst_n) begin
            l2_end_r <= '0;
            l4_ofs_r <= '0;
            l4_pay_r <= '0;
            wide_ofs_r <= '0;
            narrow_ofs_r <= '0;
            tcp_r <= 1'b0;
            is_tcp_or_udp_r <= 1'b0;
            oam_r <= 1'b0;
            ethertype_key_field_r <= '0;
            mel_r <= '0;
            sport_r <= '0;
            dport_r <= '0;
            seq_r <= '0;
            tflags_r <= '0;
            custom_val_r <= '0;
            ccm_r <= 1'b0;
        end else if (state_r == AKLP_ST_PARSE) begin
            for (int t = 0; t < `AKLP_MAX_TAGS; t++) begin
                if (is_tpid(fword(pos))) begin
                    pos = OW'(pos + `AKLP_VLAN_TAG_LEN);
                end
            end
            et = fword(pos);
            l2e = OW'(pos + `AKLP_ETHERTYPE_KEY_FIELD_LEN);
            ip4 = (et == `AKLP_ETHERTYPE_KEY_FIELD_IPV4);
            ip6 = (et == `AKLP_ETHERTYPE_KEY_FIELD_IPV6);
            if (ip4) begin
                proto = fbyte(OW'(l2e + `AKLP_IPV4_PROTO_POS));
                l4o = OW'(l2e + `AKLP_IPV4_HDR_LEN);
            end else if (ip6) begin
                proto = fbyte(OW'(l2e + `AKLP_IPV6_NH_POS));
                l4o = OW'(l2e + `AKLP_IPV6_HDR_LEN);
            end
            tu = (ip4 || ip6) && (proto == `AKLP_PROTO_TCP ||
                                  proto == `AKLP_PROTO_UDP);
            is_tcp_or_udp_r <= tu;
            tcp_r <= (ip4 || ip6) && proto == `AKLP_PROTO_TCP;
            l2_end_r <= l2e;
            l4_ofs_r <= l4o;
            if (proto == `AKLP_PROTO_TCP) begin
                l4_pay_r <= OW'(l4o + {fbyte(OW'(l4o + `AKLP_TCP_DOFS_POS))
                                       >> 4, 2'b00});
            end else begin
                l4_pay_r <= OW'(l4o + `AKLP_UDP_HDR_LEN);
            end
            sport_r <= tu ? fword(l4o) : 16'h0000;
            dport_r <= tu ? fword(OW'(l4o + 2'd2)) : 16'h0000;
            seq_r <= {fword(OW'(l4o + `AKLP_TCP_SEQ_POS)),
                      fword(OW'(l4o + `AKLP_TCP_SEQ_POS + 2'd2))};
            tflags_r <= fbyte(OW'(l4o + `AKLP_TCP_FLAG_POS));
            custom_val_r <= fword(cust_ofs_r);
            oam_r <= (et == `AKLP_ETHERTYPE_KEY_FIELD_OAM);
            ccm_r <= (fbyte(OW'(l2e + 1'b1)) == `AKLP_CCM_OPCODE);
            mel_r <= 3'(fbyte(l2e) >> 5);
            ethertype_key_field_r <= et;
            cbase = cls_r.is_eth ? l2e : '0;
            wide_ofs_r <= OW'(cbase + cls_r.wide_ptr);
            narrow_ofs_r <= OW'(cbase + cls_r.narrow_ptr);
        end
    end

    // Byte windows
    logic [`AKLP_IP_SNIP_BYTES*8-1:0] ip_snip;
    logic [`AKLP_L4_SNIP_BYTES*8-1:0] l4_snip;
    logic [`AKLP_WIDE_BYTES*8-1:0] wide_win;
    logic [`AKLP_NARROW_BYTES*8-1:0] narrow_win;
    logic [`AKLP_CCM_CNT_BYTES*8-1:0] ccm_cnt;
    logic [OW-1:0] l4_snip_ofs;
    logic [OW-1:0] ccm_ofs;

    assign l4_snip_ofs = is_tcp_or_udp_r ? l4_pay_r : l4_ofs_r;
    assign ccm_ofs = OW'(l2_end_r + `AKLP_CCM_CNT_POS);

    aklp_window #(.FB(MAXB), .NB(`AKLP_IP_SNIP_BYTES), .OW(OW)) u_ip_win (
        .frame(frame_r), .ofs(l4_ofs_r), .win(ip_snip));
    aklp_window #(.FB(MAXB), .NB(`AKLP_L4_SNIP_BYTES), .OW(OW)) u_l4_win (
        .frame(frame_r), .ofs(l4_snip_ofs), .win(l4_snip));
    aklp_window #(.FB(MAXB), .NB(`AKLP_WIDE_BYTES), .OW(OW)) u_wide_win (
        .frame(frame_r), .ofs(wide_ofs_r), .win(wide_win));
    aklp_window #(.FB(MAXB), .NB(`AKLP_NARROW_BYTES), .OW(OW)) u_nar_win (
        .frame(frame_r), .ofs(narrow_ofs_r), .win(narrow_win));
    aklp_window #(.FB(MAXB), .NB(`AKLP_CCM_CNT_BYTES), .OW(OW)) u_ccm_win (
        .frame(frame_r), .ofs(ccm_ofs), .win(ccm_cnt));

    // Range checkers
    logic [NR-1:0] rng_hit;
    for (genvar g = 0; g < NR; g++) begin : g_rng
        aklp_range_chk u_chk (
            .sel(aklp_rng_sel_t'(rng_type_r[g*SW +: SW])),
            .lo(bound_r[g][15:0]),
            .hi(bound_r[g][31:16]),
            .sport(sport_r),
            .dport(dport_r),
            .vid(cls_r.vid),
            .dscp(cls_r.dscp),
            .custom(custom_val_r),
            .hit(rng_hit[g])
        );
    end

    // Key register, loaded in the build cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_r <= '0;
            key_valid_r <= 1'b0;
        end else begin
            key_valid_r <= (state_r == AKLP_ST_BUILD);
            if (state_r == AKLP_ST_BUILD) begin
                key_r.range_check_mask <= rng_hit;
                key_r.src_port_equals_dst_port <=
                    is_tcp_or_udp_r && (sport_r == dport_r);
                key_r.tcp_seq_is_zero <= tcp_r && (seq_r == '0);
                key_r.tcp_fin_bit <= tcp_r & tflags_r[0];
                key_r.tcp_syn_bit <= tcp_r & tflags_r[1];
                key_r.tcp_rst_bit <= tcp_r & tflags_r[2];
                key_r.tcp_psh_bit <= tcp_r & tflags_r[3];
                key_r.tcp_ack_bit <= tcp_r & tflags_r[4];
                key_r.tcp_urg_bit <= tcp_r & tflags_r[5];
                key_r.is_tcp_or_udp <= is_tcp_or_udp_r;
                key_r.ip_payload_snippet <= ip_snip;
                key_r.transport_payload_snippet <= l4_snip;
                key_r.ccm_loss_counters_zero <=
                    oam_r && ccm_r && (ccm_cnt == '0);
                key_r.oam_ethertype_flag <= oam_r;
                // One-hot maintenance level replaces the EtherType
                key_r.ethertype_key_field <=
                    oam_r ? {8'h00, 8'h01 << mel_r} : ethertype_key_field_r;
                key_r.custom_window_wide <= wide_win;
                key_r.custom_window_narrow <= narrow_win;
            end
        end
    end

    // Count of keys produced
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_cnt_r <= 32'h0000_0000;
        end else if (state_r == AKLP_ST_BUILD) begin
            key_cnt_r <= key_cnt_r + 32'h0000_0001;
        end
    end

    assign in_ready = in_ready_r;
    assign key_valid = key_valid_r;
    assign key = key_r;
    assign reg_rdata = rdata_r;

endmodule : aklp_key_l4

`default_nettype wire

// ===== aklp_key_l4_properties.sv
// Port checks of the key builder.
// Assumes it is bound to aklp_key_l4 from the bench.
`timescale 1ns/1ps
`default_nettype none
`include "aklp_consts.svh"
module aklp_key_l4_chk #(
    parameter int MAXB = 256
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Frame stream
    input wire logic in_valid,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [7:0] in_byte,
    input wire aklp_pkg::aklp_class_t in_class,
    input wire logic in_ready,
    // Key
    input wire logic key_valid,
    input wire aklp_pkg::aklp_key_t key,
    // Registers
    input wire logic [`AKLP_ADDR_W-1:0] reg_addr,
    input wire logic [`AKLP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`AKLP_DATA_W-1:0] reg_rdata
);
    import aklp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence eop_taken;
        in_valid && in_ready && in_eop;
    endsequence
    sequence busy_gap;
        !in_ready [*2] ##1 in_ready;
    endsequence
    key_latency_a: assert property (eop_taken |-> ##3 key_valid)
        else $error("key not three cycles after last byte");
    ready_gap_a: assert property (eop_taken |=> busy_gap)
        else $error("ready gap after last byte wrong");
    key_pulse_a: assert property (key_valid |=> !key_valid)
        else $error("key valid longer than one cycle");
    key_hold_a: assert property (!key_valid |-> $stable(key))
        else $error("key changed without key valid");
    port_eq_a: assert property (
        key_valid && !key.is_tcp_or_udp |-> !key.src_port_equals_dst_port)
        else $error("port flag set on non transport frame");
    tcp_bits_a: assert property (key_valid && !key.is_tcp_or_udp |->
        !(key.tcp_seq_is_zero || key.tcp_fin_bit || key.tcp_syn_bit))
        else $error("tcp bits set on non transport frame");
    oam_field_a: assert property (key_valid && key.oam_ethertype_flag |->
        key.ethertype_key_field[15:8] == 8'h00 &&
        $onehot(key.ethertype_key_field[7:0]))
        else $error("oam level field not one hot");
    ccm_oam_a: assert property (
        key_valid && key.ccm_loss_counters_zero |-> key.oam_ethertype_flag)
        else $error("ccm flag without oam flag");
    oam_l4_a: assert property (
        key_valid && key.oam_ethertype_flag |-> !key.is_tcp_or_udp)
        else $error("oam frame marked as transport");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr == 8'h30 |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : aklp_key_l4_chk
`default_nettype wire

// ===== aklp_src.sv
// Upstream parser model: sends the frame image in fb byte by byte.
// Assumes the bench fills fb and waits out reset first.
`timescale 1ns/1ps
`default_nettype none
module aklp_src (
    // Clock
    input wire logic clk,
    // Byte stream
    output logic in_valid,
    output logic in_sop,
    output logic in_eop,
    output logic [7:0] in_byte,
    input wire logic in_ready
);
    logic [7:0] fb [0:127];
    initial begin
        in_valid = 1'b0;
        in_sop = 1'b0;
        in_eop = 1'b0;
        in_byte = 8'h00;
    end
    task automatic send(input int len);
        @(posedge clk);
        for (int i = 0; i < len; i++) begin
            in_valid <= 1'b1;
            in_sop <= (i == 0);
            in_eop <= (i == len - 1);
            in_byte <= fb[i];
            @(negedge clk);
            while (in_ready !== 1'b1) @(negedge clk);
            @(posedge clk);
        end
        in_valid <= 1'b0;
        in_eop <= 1'b0;
        // Idle byte flips so nothing leans on a stale value
        in_byte <= ~fb[len - 1];
    endtask : send
endmodule : aklp_src
`default_nettype wire

// ===== tb_aklp_key_l4.sv
// Bench of the key builder: register access and five frames.
// Assumes design, checker and source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_aklp_key_l4;
    import aklp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic in_valid, in_sop, in_eop, in_ready, key_valid, reg_wr, reg_rd;
    logic [7:0] in_byte, reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    aklp_class_t cls;
    aklp_key_t key;
    int n_mismatch = 0;
    int checked = 0;
    wire [6:0] tbits = {key.tcp_seq_is_zero, key.tcp_urg_bit,
        key.tcp_ack_bit, key.tcp_psh_bit, key.tcp_rst_bit,
        key.tcp_syn_bit, key.tcp_fin_bit};
    always #10 clk = ~clk;
    aklp_src src (.clk(clk), .in_valid(in_valid), .in_sop(in_sop),
        .in_eop(in_eop), .in_byte(in_byte), .in_ready(in_ready));
    aklp_key_l4 #(.MAXB(256)) DUT (.clk(clk), .arst_n(arst_n),
        .in_valid(in_valid), .in_sop(in_sop), .in_eop(in_eop),
        .in_byte(in_byte), .in_class(cls), .in_ready(in_ready),
        .key_valid(key_valid), .key(key), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic cmp(input string nm, input logic [455:0] e, g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp("reg_rdata", 456'(e), 456'(reg_rdata));
    endtask : rd
    function automatic logic [455:0] snip(input int s, input int n);
        logic [455:0] r;
        r = '0;
        for (int k = 0; k < n; k++) r = {r[447:0], src.fb[s + k]};
        return r;
    endfunction : snip
    task automatic frame(input int tags, input logic [15:0] et,
        input logic [7:0] pr, input logic eth, input int wp, np);
        int l2;
        int l4;
        int n;
        logic tcp;
        logic tu;
        l2 = 14 + 4 * tags;
        l4 = l2 + 20;
        tcp = (pr == 8'h06);
        tu = tcp || (pr == 8'h11);
        for (int i = 0; i < 128; i++) src.fb[i] = (i < 96) ? 8'(i) : 8'h00;
        for (int t = 0; t < tags; t++) src.fb[12 + 4 * t] = 8'h81;
        for (int t = 0; t < tags; t++) src.fb[13 + 4 * t] = 8'h00;
        {src.fb[l2 - 2], src.fb[l2 - 1]} = et;
        src.fb[l2] = (et == 16'h8902) ? 8'ha0 : 8'h45;
        src.fb[l2 + 1] = 8'h01;
        src.fb[l2 + 9] = pr;
        if (tcp) begin
            {src.fb[l4 + 2], src.fb[l4 + 3]} = {src.fb[l4], src.fb[l4 + 1]};
            for (int i = 4; i < 8; i++) src.fb[l4 + i] = 8'h00;
            src.fb[l4 + 12] = 8'h50;
            src.fb[l4 + 13] = 8'h15;
        end
        if (et == 16'h8902 && !pr)
            for (int i = 58; i < 70; i++) src.fb[l2 + i] = 8'h00;
        @(posedge clk) cls <= '{12'h123, 6'h10, eth, 8'(wp), 8'(np)};
        src.send(96);
        n = 0;
        while (key_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cmp("key_valid", 456'h1, 456'(key_valid));
        cmp("is_tcp_or_udp", 456'(tu), 456'(key.is_tcp_or_udp));
        cmp("port_eq", 456'(tcp), 456'(key.src_port_equals_dst_port));
        cmp("tcp_bits", tcp ? 456'h55 : 456'h0, 456'(tbits));
        if (et == 16'h0800) begin
            cmp("ip_snip", snip(l4, 12), 456'(key.ip_payload_snippet));
            n = tcp ? l4 + 20 : (tu ? l4 + 8 : l4);
            cmp("l4_snip", snip(n, 8),
                456'(key.transport_payload_snippet));
        end
        n = eth ? l2 : 0;
        cmp("wide", snip(n + wp, 57), 456'(key.custom_window_wide));
        cmp("narrow", snip(n + np, 24),
            456'(key.custom_window_narrow));
        cmp("oam", 456'(et == 16'h8902), 456'(key.oam_ethertype_flag));
        cmp("ccm", 456'(et == 16'h8902 && !pr),
            456'(key.ccm_loss_counters_zero));
        cmp("ethertype_key_field", (et == 16'h8902) ? 456'h20 : 456'(et),
            456'(key.ethertype_key_field));
    endtask : frame
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cls = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h1c, 32'hffff_0000);
        rd(8'h20, 32'h0000_0000);
        wr(8'h00, 32'h2223_2223);
        wr(8'h04, 32'hffff_2224);
        wr(8'h08, 32'h2223_0000);
        wr(8'h0c, 32'h0123_0123);
        wr(8'h10, 32'h003f_0011);
        wr(8'h14, 32'h0203_0203);
        wr(8'h20, 32'h00fa_c688);
        wr(8'h24, 32'h0000_0002);
        wr(8'h2c, 32'h0000_0077);
        rd(8'h24, 32'h0000_0002);
        rd(8'h30, 32'h0000_0000);
        frame(0, 16'h0800, 8'h06, 1'b1, 0, 2);
        cmp("mask", 456'h2d, 456'(key.range_check_mask));
        frame(1, 16'h0800, 8'h11, 1'b1, 3, 0);
        frame(0, 16'h0800, 8'h01, 1'b0, 5, 7);
        frame(0, 16'h8902, 8'h01, 1'b0, 0, 0);
        frame(0, 16'h8902, 8'h00, 1'b1, 0, 1);
        rd(8'h28, 32'h0000_c12c);
        rd(8'h2c, 32'h0000_0005);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_aklp_key_l4
bind aklp_key_l4 aklp_key_l4_chk #(.MAXB(MAXB)) chk (.clk(clk),
    .arst_n(arst_n), .in_valid(in_valid), .in_sop(in_sop),
    .in_eop(in_eop), .in_byte(in_byte), .in_class(in_class),
    .in_ready(in_ready), .key_valid(key_valid), .key(key),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
